/* File: design/gpio_bank_pkg.sv */
// Purpose: Constants and types for the general purpose pin bank.
// Assumes: One core clock at 50 MHz.
// Notes: Pin positions describe the fixed alternate-function map.
package gpio_bank_pkg;
   localparam int PIN_COUNT = 54;
   localparam int CLK_PERIOD_NS = 20;
   localparam int SAMPLE_INTERVAL_NS = 128;
   // Least time rounds up to whole cycles.
   localparam int SAMPLE_CYCLES =
      (SAMPLE_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] SAMPLE_LAST = 3'(SAMPLE_CYCLES - 1);
   localparam logic [2:0] DIV_RESET = 3'h0;
   localparam logic [PIN_COUNT-1:0] FUNC_RESET = '0;
   localparam logic [PIN_COUNT-1:0] DIR_RESET = '0;
   localparam logic [PIN_COUNT-1:0] ASEL_RESET = '0;
   localparam logic [PIN_COUNT-1:0] DATA_RESET = '0;
   localparam int PART_RESETS = 4;
   localparam int EVENT_PIN = 5;
   localparam int EXP_INT_PIN = 8;
   localparam int HP_BASE_PIN = 9;
   localparam int HP_GROUP_SIZE = 9;
   localparam int HP_GROUPS = 5;
   localparam int HP_BUTTON = 0;
   localparam int HP_PRESENCE = 1;
   localparam int HP_FAULT = 2;
   localparam int HP_GOOD = 3;
   localparam int HP_LATCH = 4;
   localparam int HP_ATTN = 5;
   localparam int HP_PWR_IND = 6;
   localparam int HP_PWR_EN = 7;
   localparam int HP_SLOT_RST = 8;
   localparam int LINK_PORTS = 12;
   localparam int PORT0_UP_PIN = 4;
   localparam int PORT0_ACT_PIN = 5;
   localparam int LINK_BASE_PIN = 22;
   typedef enum logic [1:0] {
      MODE_INPUT,
      MODE_OUTPUT,
      MODE_ALT
   } pin_mode_type;
endpackage : gpio_bank_pkg

/* File: design/switch_gpio_port_block.sv */
// Purpose: Bank of general purpose pins with alternate functions.
// Assumes: Pin inputs may be asynchronous; config arrives by strobes.
// Notes: Pins are three signals each: level in, drive value, enable.
`timescale 1ns/1ns
//
// Contract
// R1: 54 pins: input, output or alternate function.
// R2: Fundamental reset returns all pins to input.
// R3: Inputs double-flopped, sampled at most every 128 ns.
// R4: Function and direction bits select pin mode.
// R5: Input pins are sampled into data bits.
// R6: Data read always returns sampled pin level.
// R7: Output pins drive the written data bit.
// R8: Alternate select field picks function 0 or 1.
// R9: Function 0 map: resets, event, expander, hot-plug.
// R10: Function 1 map: link-up and link-active outputs.
// R11: Indicator, enable, reset, event are outputs; rest inputs.
// R12: Alternate pin direction follows its selected signal.
// R13: Unselected alternate inputs held at inactive level.
// R14: Free-running divider spaces the input samples.
module switch_gpio_port_block import gpio_bank_pkg::*; (
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   input wire logic [PIN_COUNT-1:0] pin_in,
   output logic [PIN_COUNT-1:0] pin_out,
   output logic [PIN_COUNT-1:0] pin_oe_out,
   input wire logic cfg_write_in,
   input wire logic [PIN_COUNT-1:0] function_wdata_in,
   input wire logic [PIN_COUNT-1:0] direction_wdata_in,
   input wire logic [PIN_COUNT-1:0] alt_select_wdata_in,
   input wire logic data_write_in,
   input wire logic [PIN_COUNT-1:0] data_wdata_in,
   output logic [PIN_COUNT-1:0] pin_function_select_out,
   output logic [PIN_COUNT-1:0] pin_direction_config_out,
   output logic [PIN_COUNT-1:0] alternate_signal_select_out,
   output logic [PIN_COUNT-1:0] pin_data_value_out,
   input wire logic general_event_out_n_in,
   input wire logic [HP_GROUPS-1:0] slot_attention_indicator_n_in,
   input wire logic [HP_GROUPS-1:0] slot_power_indicator_n_in,
   input wire logic [HP_GROUPS-1:0] slot_power_enable_in,
   input wire logic [HP_GROUPS-1:0] slot_reset_n_in,
   input wire logic [LINK_PORTS-1:0] port_link_up_n_in,
   input wire logic [LINK_PORTS-1:0] port_link_active_n_in,
   output logic [PART_RESETS-1:0] partition_fundamental_reset_n_out,
   output logic expander_interrupt_n_out,
   output logic [HP_GROUPS-1:0] slot_attention_button_n_out,
   output logic [HP_GROUPS-1:0] slot_presence_detect_n_out,
   output logic [HP_GROUPS-1:0] slot_power_fault_n_out,
   output logic [HP_GROUPS-1:0] slot_power_good_n_out,
   output logic [HP_GROUPS-1:0] slot_retention_latch_n_out
);

   // ********************************************************
   // Functions
   // ********************************************************
   function automatic pin_mode_type pin_mode(input logic f, input logic d);
      if (f) begin
         pin_mode = MODE_ALT;
      end else if (d) begin
         pin_mode = MODE_OUTPUT;
      end else begin
         pin_mode = MODE_INPUT;
      end
   endfunction : pin_mode

   // Pin that carries signal k of hot-plug group g.
   function automatic int hp_pin(input int g, input int k);
      hp_pin = HP_BASE_PIN + g * HP_GROUP_SIZE + k;
   endfunction : hp_pin

   // Pins whose alternate function in the given set is an output.
   function automatic logic [PIN_COUNT-1:0] alt_out_mask(input logic sel);
      logic [PIN_COUNT-1:0] m;
      m = '0;
      if (!sel) begin
         m[EVENT_PIN] = 1'b1;
         for (int g = 0; g < HP_GROUPS; g++) begin
            for (int k = HP_ATTN; k <= HP_SLOT_RST; k++) begin
               m[hp_pin(g, k)] = 1'b1;
            end
         end
      end else begin
         m[PORT0_UP_PIN] = 1'b1;
         m[PORT0_ACT_PIN] = 1'b1;
         for (int p = 0; p < 2 * (LINK_PORTS - 1); p++) begin
            m[LINK_BASE_PIN + p] = 1'b1;
         end
      end
      alt_out_mask = m;
   endfunction : alt_out_mask

   // ********************************************************
   // Configuration registers
   // ********************************************************
   logic [PIN_COUNT-1:0] func;
   logic [PIN_COUNT-1:0] dir;
   logic [PIN_COUNT-1:0] asel;
   logic [PIN_COUNT-1:0] out_data;

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         func <= FUNC_RESET; // [R2]
         dir <= DIR_RESET; // [R2]
         asel <= ASEL_RESET;
      end else if (cfg_write_in) begin
         func <= function_wdata_in;
         dir <= direction_wdata_in;
         asel <= alt_select_wdata_in;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         out_data <= DATA_RESET;
      end else if (data_write_in) begin
         out_data <= data_wdata_in;
      end
   end

   assign pin_function_select_out = func;
   assign pin_direction_config_out = dir;
   assign alternate_signal_select_out = asel;

   // ********************************************************
   // Input synchroniser and sample divider
   // ********************************************************
   logic [PIN_COUNT-1:0] sync1;
   logic [PIN_COUNT-1:0] sync2;
   logic [2:0] div_count;
   logic tick;

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= pin_in; // [R3]
         sync2 <= sync1; // [R3]
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         div_count <= DIV_RESET;
      end else if (div_count == SAMPLE_LAST) begin
         div_count <= DIV_RESET; // [R14]
      end else begin
         div_count <= div_count + 3'h1; // [R14]
      end
   end

   assign tick = (div_count == SAMPLE_LAST);

   // The sample holds the pin level in every mode.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         pin_data_value_out <= DATA_RESET;
      end else if (tick) begin
         pin_data_value_out <= sync2; // [R3] [R5] [R6]
      end
   end

   // ********************************************************
   // Pin drivers
   // ********************************************************
   logic [PIN_COUNT-1:0] af0_val;
   logic [PIN_COUNT-1:0] af1_val;
   logic [PIN_COUNT-1:0] af0_mask;
   logic [PIN_COUNT-1:0] af1_mask;
   logic [PIN_COUNT-1:0] next_pin_out;
   logic [PIN_COUNT-1:0] next_pin_oe;

   assign af0_mask = alt_out_mask(1'b0); // [R9] [R11]
   assign af1_mask = alt_out_mask(1'b1); // [R10] [R11]

   always_comb begin
      af0_val = '1;
      af1_val = '1;
      af0_val[EVENT_PIN] = general_event_out_n_in; // [R9]
      for (int g = 0; g < HP_GROUPS; g++) begin
         af0_val[hp_pin(g, HP_ATTN)] = slot_attention_indicator_n_in[g];
         af0_val[hp_pin(g, HP_PWR_IND)] = slot_power_indicator_n_in[g];
         af0_val[hp_pin(g, HP_PWR_EN)] = slot_power_enable_in[g];
         af0_val[hp_pin(g, HP_SLOT_RST)] = slot_reset_n_in[g];
      end
      af1_val[PORT0_UP_PIN] = port_link_up_n_in[0]; // [R10]
      af1_val[PORT0_ACT_PIN] = port_link_active_n_in[0];
      for (int p = 1; p < LINK_PORTS; p++) begin
         af1_val[LINK_BASE_PIN + 2 * (p - 1)] = port_link_up_n_in[p];
         af1_val[LINK_BASE_PIN + 2 * (p - 1) + 1] = port_link_active_n_in[p];
      end
   end

   always_comb begin
      next_pin_out = '0;
      next_pin_oe = '0;
      for (int i = 0; i < PIN_COUNT; i++) begin // [R1]
         case (pin_mode(func[i], dir[i])) // [R4]
            MODE_OUTPUT: begin
               next_pin_oe[i] = 1'b1;
               next_pin_out[i] = out_data[i]; // [R7]
            end
            MODE_ALT: begin
               next_pin_oe[i] = asel[i] ? af1_mask[i] : af0_mask[i]; // [R12]
               next_pin_out[i] = asel[i] ? af1_val[i] : af0_val[i]; // [R8]
            end
            default: begin
               next_pin_oe[i] = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         pin_out <= '0;
         pin_oe_out <= '0; // [R2]
      end else begin
         pin_out <= next_pin_out;
         pin_oe_out <= next_pin_oe;
      end
   end

   // ********************************************************
   // Alternate inputs to the core
   // ********************************************************
   logic [PIN_COUNT-1:0] af0_in_sel;
   logic [PIN_COUNT-1:0] alt_level;
   // Pins in alternate mode with function 0 chosen and not an output.
   assign af0_in_sel = func & ~asel & ~af0_mask;
   // Unselected alternate inputs read as their inactive high level.
   assign alt_level = pin_data_value_out | ~af0_in_sel; // [R13]

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         partition_fundamental_reset_n_out <= '1;
         expander_interrupt_n_out <= 1'b1;
         slot_attention_button_n_out <= '1;
         slot_presence_detect_n_out <= '1;
         slot_power_fault_n_out <= '1;
         slot_power_good_n_out <= '1;
         slot_retention_latch_n_out <= '1;
      end else begin
         partition_fundamental_reset_n_out <= alt_level[PART_RESETS-1:0];
         expander_interrupt_n_out <= alt_level[EXP_INT_PIN]; // [R9]
         for (int g = 0; g < HP_GROUPS; g++) begin
            slot_attention_button_n_out[g] <= alt_level[hp_pin(g, HP_BUTTON)];
            slot_presence_detect_n_out[g] <= alt_level[hp_pin(g, HP_PRESENCE)];
            slot_power_fault_n_out[g] <= alt_level[hp_pin(g, HP_FAULT)];
            slot_power_good_n_out[g] <= alt_level[hp_pin(g, HP_GOOD)];
            slot_retention_latch_n_out[g] <= alt_level[hp_pin(g, HP_LATCH)];
         end
      end
   end

   // ********************************************************
   // Assertions
   // ********************************************************
   sequence sample_gap;
      !tick [*6];
   endsequence
   a_reset_to_input: assert property (@(posedge clk_sys_in) // [R2]
      !rst_b_in |=> func == '0 && dir == '0 && pin_oe_out == '0)
      else $error("pins not inputs after reset");
   a_sample_spacing: assert property (@(posedge clk_sys_in) // [R3]
      disable iff (!rst_b_in) tick |=> sample_gap ##1 tick)
      else $error("sample interval wrong");
   a_sample_hold: assert property (@(posedge clk_sys_in) // [R14]
      disable iff (!rst_b_in) !tick |=> $stable(pin_data_value_out))
      else $error("data changed between samples");
   a_sample_value: assert property (@(posedge clk_sys_in) // [R6]
      disable iff (!rst_b_in)
      tick |=> pin_data_value_out == $past(sync2))
      else $error("sample not pin level");
   a_output_drive: assert property (@(posedge clk_sys_in) // [R7]
      disable iff (!rst_b_in) 1'b1 |=>
      ((pin_oe_out & $past(~func & dir)) == $past(~func & dir)) &&
      ((pin_out & $past(~func & dir)) == $past(out_data & ~func & dir)))
      else $error("output pin not driven with data");
   a_input_float: assert property (@(posedge clk_sys_in) // [R4]
      disable iff (!rst_b_in) 1'b1 |=>
      (pin_oe_out & $past(~func & ~dir)) == '0)
      else $error("input pin driven");
   a_alt_direction: assert property (@(posedge clk_sys_in) // [R12]
      disable iff (!rst_b_in) 1'b1 |=>
      (pin_oe_out & $past(func)) ==
      $past(func & ((asel & af1_mask) | (~asel & af0_mask))))
      else $error("alternate pin direction wrong");
   a_reset_inactive: assert property (@(posedge clk_sys_in) // [R13]
      disable iff (!rst_b_in)
      !af0_in_sel[0] |=> partition_fundamental_reset_n_out[0])
      else $error("unselected reset not held high");

endmodule : switch_gpio_port_block

/* File: dv/gpio_board_model.sv */
// Purpose: Board side of the pin bank, the slot and status wiring.
// Assumes: The board puts a level on every pin that the bank leaves free.
// Notes: A pin that the bank drives shows the bank's value.
`timescale 1ns/1ns
module gpio_board_model import gpio_bank_pkg::*; (
   input wire logic [PIN_COUNT-1:0] drive_in,
   input wire logic [PIN_COUNT-1:0] enable_in,
   input wire logic [PIN_COUNT-1:0] board_in,
   output logic [PIN_COUNT-1:0] level_out
);
   // ****************************************
   // Wire resolution.
   // ****************************************
   assign level_out = (enable_in & drive_in) | (~enable_in & board_in);
endmodule : gpio_board_model

/* File: dv/tb.sv */
// Purpose: Self-checking bench for the pin bank.
// Assumes: The board model resolves every pin level.
// Notes: Expected values come from the pin map and the sample rate.
`timescale 1ns/1ns
module tb import gpio_bank_pkg::*;;
   typedef logic [PIN_COUNT-1:0] vec_type;
   typedef struct {int pin; logic f; logic d; logic a; logic oe; logic v;}
      row_type;
   // Pin, function, direction, select, expected enable and drive.
   row_type rows [16] = '{'{7,0,0,0,0,0}, '{7,0,1,0,1,1}, '{5,1,0,0,1,1},
      '{5,1,1,1,1,0}, '{4,1,0,0,0,0}, '{4,1,0,1,1,0}, '{9,1,0,0,0,0},
      '{14,1,0,0,1,0}, '{16,1,0,0,1,1}, '{22,1,0,1,1,1}, '{44,1,0,1,0,0},
      '{0,1,1,0,0,0}, '{6,0,1,0,1,0}, '{15,1,0,0,1,1}, '{53,1,0,0,1,0},
      '{43,1,0,1,1,0}};
   localparam vec_type PAT = 54'h2aaaaaaaaaaaaa;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic cwr = 1'b0;
   logic dwr = 1'b0;
   vec_type fw = '0, dw = '0, aw = '0, wd = '0, board = '0;
   vec_type lvl, pout, poe, rb_f, rb_d, rb_a, rb_v, prev;
   logic ge_n = 1'b1;
   logic [4:0] attn_n = 5'h00, ind_n = 5'h1f, pen = 5'h01, srst_n = 5'h00;
   logic [11:0] up_n = 12'h002, act_n = 12'h000;
   logic [3:0] prst_n;
   logic exp_n;
   logic [4:0] btn_n, pd_n, pf_n, pg_n, lat_n;
   int miscompares = 0;
   int checks = 0;
   int n, gap, mingap;
   vec_type one;

   always #10 clk = ~clk;

   gpio_board_model board_model (.drive_in(pout), .enable_in(poe),
      .board_in(board), .level_out(lvl));

   switch_gpio_port_block dut (.clk_sys_in(clk), .rst_b_in(rst_b),
      .pin_in(lvl), .pin_out(pout), .pin_oe_out(poe), .cfg_write_in(cwr),
      .function_wdata_in(fw), .direction_wdata_in(dw),
      .alt_select_wdata_in(aw), .data_write_in(dwr), .data_wdata_in(wd),
      .pin_function_select_out(rb_f), .pin_direction_config_out(rb_d),
      .alternate_signal_select_out(rb_a), .pin_data_value_out(rb_v),
      .general_event_out_n_in(ge_n), .slot_attention_indicator_n_in(attn_n),
      .slot_power_indicator_n_in(ind_n), .slot_power_enable_in(pen),
      .slot_reset_n_in(srst_n), .port_link_up_n_in(up_n),
      .port_link_active_n_in(act_n),
      .partition_fundamental_reset_n_out(prst_n),
      .expander_interrupt_n_out(exp_n), .slot_attention_button_n_out(btn_n),
      .slot_presence_detect_n_out(pd_n), .slot_power_fault_n_out(pf_n),
      .slot_power_good_n_out(pg_n), .slot_retention_latch_n_out(lat_n));

   // ****************************************
   // Shared tasks.
   // ****************************************
   task automatic print_verdict();
      if (miscompares == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : chk

   task automatic cfg(input vec_type f, input vec_type d, input vec_type a);
      @(posedge clk);
      cwr <= 1'b1;
      fw <= f;
      dw <= d;
      aw <= a;
      @(posedge clk);
      cwr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask : cfg

   task automatic wait_data(input vec_type e);
      n = 0;
      while (rb_v !== e) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 20) begin
            chk(1'b0, "sample timeout");
            print_verdict();
         end
      end
   endtask : wait_data

   // ****************************************
   // Main sequence.
   // ****************************************
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (20) @(posedge clk);
      #1;
      chk(rb_f === '0 && rb_d === '0 && poe === '0, "reset config");
      chk(prst_n === 4'hf && exp_n === 1'b1, "idle in");
      chk(btn_n === 5'h1f && lat_n === 5'h1f, "idle slot");
      @(posedge clk);
      dwr <= 1'b1;
      wd <= PAT;
      @(posedge clk);
      dwr <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         one = vec_type'(1) << rows[i].pin;
         cfg(rows[i].f ? one : '0, rows[i].d ? one : '0, rows[i].a ? one : '0);
         chk(poe[rows[i].pin] === rows[i].oe, "pin oe");
         if (rows[i].oe) begin
            chk(pout[rows[i].pin] === rows[i].v, "pin val");
         end
      end
      cfg('0, PAT, ~PAT);
      chk(rb_d === PAT && rb_a === ~PAT && poe === PAT, "config");
      chk((pout & PAT) === PAT, "output data");
      wait_data(PAT);
      cfg('0, '0, '0);
      wait_data('0);
      @(posedge clk);
      board <= PAT;
      wait_data(PAT);
      chk(n >= 3 && n <= 10, "sample delay");
      mingap = 99;
      gap = -1000;
      prev = rb_v;
      repeat (80) begin
         @(posedge clk);
         board <= ~board;
         #1;
         gap++;
         if (rb_v !== prev) begin
            if (gap > 0 && gap < mingap) begin
               mingap = gap;
            end
            gap = 0;
            prev = rb_v;
         end
      end
      chk(mingap >= 7 && mingap < 99, "sample spacing");
      @(posedge clk);
      board <= 54'ha00000001400;
      cfg(54'h3e00000003f01, '0, '0);
      repeat (11) @(posedge clk);
      #1;
      chk(prst_n === 4'he && exp_n === 1'b0, "selected in");
      chk((poe & 54'h3e00000003f01) === '0, "alt in float");
      chk(btn_n === 5'h1e && pd_n === 5'h0f, "slot button");
      chk(pf_n === 5'h1e && pg_n === 5'h0f, "slot power");
      chk(lat_n === 5'h0e, "slot latch");
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(rb_f === '0 && poe === '0 && prst_n === 4'hf, "mid reset");
      print_verdict();
   end
endmodule : tb
